// [shared/wdt_pkg.sv]
// Constants, register map and field layout of the watchdog block.
package wdt_pkg;

	////////////////////////////////////////////////////////////////////////
	// Clocking and time-out figures.

	localparam int unsigned PCLK_HZ = 20_000_000;
	localparam int unsigned RC_OSC_HZ = 31_250;
	localparam int unsigned BASE_PERIOD_MS = 16;
	// Bus clocks per internal oscillator period.
	localparam int unsigned RC_DIV = PCLK_HZ / RC_OSC_HZ;
	// Oscillator periods in one base time-out.
	localparam int unsigned BASE_TICKS = RC_OSC_HZ * BASE_PERIOD_MS / 1000;
	localparam int unsigned BASE_PERIOD_CYCLES =
		PCLK_HZ / 1000 * BASE_PERIOD_MS;

	////////////////////////////////////////////////////////////////////////
	// Register map. The two documented registers keep their printed offset
	// as an index; the byte address is four times that index.

	localparam logic [15:0] PRESCALER_CONTROL_IDX = 16'h0081;
	localparam logic [15:0] CONFIG_WORD_IDX = 16'h2007;
	localparam logic [15:0] PRESCALER_CONTROL_ADDR =
		{PRESCALER_CONTROL_IDX[13:0], 2'b00};
	localparam logic [15:0] CONFIG_WORD_ADDR = {CONFIG_WORD_IDX[13:0], 2'b00};
	localparam logic [15:0] WDT_STATUS_ADDR = 16'h0000;
	localparam logic [15:0] IRQ_STATUS_ADDR = 16'h0004;
	localparam logic [15:0] IRQ_MASK_ADDR = 16'h0008;

	////////////////////////////////////////////////////////////////////////
	// Field positions.

	localparam int unsigned SCALER_ASSIGN_BIT = 3;
	localparam int unsigned SCALER_RATIO_MSB_BIT = 2;
	localparam int unsigned SCALER_RATIO_MID_BIT = 1;
	localparam int unsigned SCALER_RATIO_LSB_BIT = 0;
	localparam int unsigned FUSE_ENABLE_BIT = 2;
	localparam int unsigned STAT_TIMEOUT_FLAG_BIT = 0;
	localparam int unsigned STAT_OSC_RUN_BIT = 1;
	localparam int unsigned STAT_ASSIGN_BIT = 2;
	localparam int unsigned IRQ_BITS = 2;
	localparam int unsigned IRQ_RESET_BIT = 0;
	localparam int unsigned IRQ_WAKE_BIT = 1;

	////////////////////////////////////////////////////////////////////////
	// Values after reset.

	localparam logic [7:0] PRESCALER_CONTROL_RESET = 8'hFF;
	localparam logic [7:0] CONFIG_WORD_RESET = 8'hFF;
	localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
	localparam logic TIMEOUT_FLAG_RESET = 1'b1;

endpackage

// [core/wdt_postscaler.sv]
// Shared power-of-two scaler used by the watchdog or the general timer.
`timescale 1ns/10ps
module wdt_postscaler
	import wdt_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tick,
	input wire logic clear,
	input wire logic [2:0] ratio,
	output logic fire,
	output logic [6:0] count
);

	logic [7:0] mask_wide;
	logic [6:0] mask;

	// The low n bits of a free counter wrap every two to the n ticks.
	assign mask_wide = (8'h01 << ratio) - 8'h01;
	assign mask = mask_wide[6:0];
	assign fire = tick & ((count & mask) == mask);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= 7'h00;
		end else if (clear) begin
			count <= 7'h00;
		end else if (tick) begin
			count <= count + 7'h01;
		end
	end

endmodule

// [core/watchdog_timer.sv]
// Watchdog timer with shared postscaler and APB register slave.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
// How it works
// - Watchdog counts internal oscillator ticks; enabling it turns the oscillator on.
// - Unscaled time-out nominally elapses after 16 ms of oscillator time.
// - Expiry while running normally issues a device reset.
// - Expiry while asleep issues a wake-up instead of a reset.
// - Every expiry clears the time-out flag.
// - A cleared fuse enable bit disables the watchdog; it never expires.
// - One scaler serves timer or watchdog, chosen by assign bit; ratio sets its division.
// - Clear or sleep instruction zeroes counter and watchdog-assigned scaler.
// - Clear instruction zeroes assigned scaler, leaving assignment bit unchanged.
module watchdog_timer
	import wdt_pkg::*;
#(
	parameter int unsigned RC_DIVIDE = RC_DIV,
	parameter int unsigned BASE_TICK_COUNT = BASE_TICKS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic clear_watchdog_instr,
	input wire logic sleep_instr,
	input wire logic in_sleep,
	input wire logic general_timer_event,
	output logic general_timer_inc,
	output logic internal_rc_osc_en,
	output logic device_reset,
	output logic wake_up,
	output logic timeout_flag,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////
	// Declarations.

	logic [7:0] prescaler_control;
	logic [7:0] config_word;
	logic [IRQ_BITS-1:0] irq_status;
	logic [IRQ_BITS-1:0] irq_mask;
	logic [IRQ_BITS-1:0] irq_event;
	logic scaler_assign;
	logic scaler_ratio_msb;
	logic scaler_ratio_mid;
	logic scaler_ratio_lsb;
	logic [2:0] scaler_ratio;
	logic watchdog_fuse_enable;
	logic apb_setup;
	logic apb_write;
	logic addr_mapped;
	logic wr_prescaler;
	logic wr_config;
	logic wr_irq_status;
	logic wr_irq_mask;
	logic [31:0] next_prdata;
	logic instr_clear;
	logic [15:0] rc_cnt;
	logic [15:0] base_cnt;
	logic rc_tick;
	logic base_expire;
	logic scaler_tick;
	logic scaler_clear;
	logic scaler_fire;
	logic [6:0] scaler_count;
	logic expiry;

	////////////////////////////////////////////////////////////////////////
	// Register fields.

	assign scaler_assign = prescaler_control[SCALER_ASSIGN_BIT];
	assign scaler_ratio_msb = prescaler_control[SCALER_RATIO_MSB_BIT];
	assign scaler_ratio_mid = prescaler_control[SCALER_RATIO_MID_BIT];
	assign scaler_ratio_lsb = prescaler_control[SCALER_RATIO_LSB_BIT];
	assign scaler_ratio = {scaler_ratio_msb, scaler_ratio_mid, scaler_ratio_lsb};
	assign watchdog_fuse_enable = config_word[FUSE_ENABLE_BIT];

	////////////////////////////////////////////////////////////////////////
	// APB slave. The slave never waits, so read data is captured in the
	// setup cycle and presented from a flip-flop in the access cycle.

	assign apb_setup = psel & ~penable;
	assign apb_write = psel & penable & pwrite;
	assign pready = 1'b1;

	always_comb begin
		addr_mapped = 1'b1;
		next_prdata = 32'h0000_0000;
		unique case (paddr)
			WDT_STATUS_ADDR: begin
				next_prdata[STAT_TIMEOUT_FLAG_BIT] = timeout_flag;
				next_prdata[STAT_OSC_RUN_BIT] = internal_rc_osc_en;
				next_prdata[STAT_ASSIGN_BIT] = scaler_assign;
			end
			IRQ_STATUS_ADDR: begin
				next_prdata[IRQ_BITS-1:0] = irq_status;
			end
			IRQ_MASK_ADDR: begin
				next_prdata[IRQ_BITS-1:0] = irq_mask;
			end
			PRESCALER_CONTROL_ADDR: begin
				next_prdata[7:0] = prescaler_control;
			end
			CONFIG_WORD_ADDR: begin
				next_prdata[7:0] = config_word;
			end
			default: begin
				addr_mapped = 1'b0;
			end
		endcase
	end

	// Unmapped addresses answer with an error and read as zero.
	assign pslverr = psel & penable & ~addr_mapped;

	assign wr_prescaler = apb_write & (paddr == PRESCALER_CONTROL_ADDR);
	assign wr_config = apb_write & (paddr == CONFIG_WORD_ADDR);
	assign wr_irq_status = apb_write & (paddr == IRQ_STATUS_ADDR);
	assign wr_irq_mask = apb_write & (paddr == IRQ_MASK_ADDR);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (apb_setup && !pwrite) begin
			prdata <= next_prdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescaler_control <= PRESCALER_CONTROL_RESET;
		end else if (wr_prescaler) begin
			prescaler_control <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			config_word <= CONFIG_WORD_RESET;
		end else if (wr_config) begin
			config_word <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask <= IRQ_MASK_RESET;
		end else if (wr_irq_mask) begin
			irq_mask <= pwdata[IRQ_BITS-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Oscillator and base counter.

	assign instr_clear = clear_watchdog_instr | sleep_instr;

	assign internal_rc_osc_en = watchdog_fuse_enable;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rc_cnt <= 16'h0000;
		end else if (!watchdog_fuse_enable || instr_clear || rc_tick) begin
			rc_cnt <= 16'h0000;
		end else begin
			rc_cnt <= rc_cnt + 16'h0001;
		end
	end

	assign rc_tick = watchdog_fuse_enable & ~instr_clear &
		(rc_cnt == 16'(RC_DIVIDE - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			base_cnt <= 16'h0000;
		end else if (!watchdog_fuse_enable || instr_clear) begin
			base_cnt <= 16'h0000;
		end else if (rc_tick) begin
			if (base_expire) begin
				base_cnt <= 16'h0000;
			end else begin
				base_cnt <= base_cnt + 16'h0001;
			end
		end
	end

	assign base_expire = rc_tick & (base_cnt == 16'(BASE_TICK_COUNT - 1));

	////////////////////////////////////////////////////////////////////////
	// Shared scaler.

	assign scaler_tick = scaler_assign ? base_expire : general_timer_event;

	assign scaler_clear = scaler_assign & instr_clear;

	wdt_postscaler u_scaler (
		.pclk(pclk),
		.presetn(presetn),
		.tick(scaler_tick),
		.clear(scaler_clear),
		.ratio(scaler_ratio),
		.fire(scaler_fire),
		.count(scaler_count)
	);

	assign expiry = scaler_assign ? scaler_fire : base_expire;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			general_timer_inc <= 1'b0;
		end else begin
			general_timer_inc <= ~scaler_assign & scaler_fire;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Expiry actions.

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			device_reset <= 1'b0;
		end else begin
			device_reset <= expiry & ~in_sleep;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_up <= 1'b0;
		end else begin
			wake_up <= expiry & in_sleep;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timeout_flag <= TIMEOUT_FLAG_RESET;
		end else if (expiry) begin
			timeout_flag <= 1'b0;
		end else if (instr_clear) begin
			timeout_flag <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupts. A new event beats a write-one-to-clear in the same cycle.

	assign irq_event[IRQ_RESET_BIT] = expiry & ~in_sleep;
	assign irq_event[IRQ_WAKE_BIT] = expiry & in_sleep;

	for (genvar i = 0; i < IRQ_BITS; i++) begin : g_irq
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				irq_status[i] <= 1'b0;
			end else if (irq_event[i]) begin
				irq_status[i] <= 1'b1;
			end else if (wr_irq_status && pwdata[i]) begin
				irq_status[i] <= 1'b0;
			end
		end
	end

	assign irq = |(irq_status & irq_mask);

	////////////////////////////////////////////////////////////////////////
	// Checks.

	logic [31:0] gap_cycles;
	logic [7:0] base_seen;
	logic ratio_known;

	// Bus clocks since the base counter last started from zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_cycles <= 32'h0000_0000;
		end else if (!watchdog_fuse_enable || instr_clear || base_expire) begin
			gap_cycles <= 32'h0000_0000;
		end else begin
			gap_cycles <= gap_cycles + 32'h0000_0001;
		end
	end

	// A ratio write leaves the scaler phase undefined until the next clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ratio_known <= 1'b1;
		end else if (wr_prescaler) begin
			ratio_known <= 1'b0;
		end else if (instr_clear) begin
			ratio_known <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			base_seen <= 8'h00;
		end else if (wr_prescaler || instr_clear || expiry) begin
			base_seen <= 8'h00;
		end else if (base_expire) begin
			base_seen <= base_seen + 8'h01;
		end
	end

	// The count a fuse write stops is one cycle behind the fuse itself.
	osc_follows_fuse_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		(rc_cnt != 16'h0000) |-> $past(internal_rc_osc_en)
		&& $past(watchdog_fuse_enable))
		else $error("oscillator counting while the watchdog is off");
	base_period_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		base_expire |-> gap_cycles == 32'(RC_DIVIDE * BASE_TICK_COUNT - 1))
		else $error("base time-out length wrong");
	reset_on_run_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		expiry && !in_sleep |=> device_reset && !wake_up ##1 !device_reset)
		else $error("expiry while running gave no single reset pulse");
	wake_on_sleep_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		expiry && in_sleep |=> wake_up && !device_reset)
		else $error("expiry in sleep did not wake without reset");
	flag_cleared_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		(device_reset || wake_up) |-> !timeout_flag)
		else $error("time-out flag not cleared by expiry");
	fuse_disables_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		!watchdog_fuse_enable [*2] |=> !device_reset && !wake_up)
		else $error("watchdog expired with the fuse cleared");
	timer_routing_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		!scaler_assign && general_timer_event && scaler_ratio == 3'h0
		|=> general_timer_inc)
		else $error("general timer did not get the unscaled event");
	instr_clears_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		instr_clear |=> rc_cnt == 16'h0000 && base_cnt == 16'h0000
		&& (!$past(scaler_assign) || scaler_count == 7'h00))
		else $error("instruction left the watchdog counts running");
	assign_kept_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		clear_watchdog_instr && !wr_prescaler |=> $stable(scaler_assign))
		else $error("clear instruction changed the scaler assignment");
	scaled_timeout_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		expiry && scaler_assign && ratio_known
		|-> base_seen == 8'((9'h001 << scaler_ratio) - 9'h001))
		else $error("scaled time-out ratio wrong");

endmodule

// [tb/watchdog_timer_with_postscaler_tb.sv]
// Self-checking bench for the watchdog block and its register slave.
`timescale 1ns/10ps
module watchdog_timer_with_postscaler_tb
	import wdt_pkg::*;
;

////////////////////////////////////////////////////////////////////////////
localparam int RDIV = 4;
localparam int BTC = 5;
localparam int P = RDIV * BTC;
localparam int LIMIT = 20000;

logic pclk = 0;
logic presetn = 0;
logic psel = 0;
logic penable = 0;
logic pwrite = 0;
logic [15:0] paddr = '0;
logic [31:0] pwdata = '0;
logic clear_watchdog_instr = 0;
logic sleep_instr = 0;
logic in_sleep = 0;
logic general_timer_event = 0;
logic [31:0] prdata;
logic pready;
logic pslverr;
logic general_timer_inc;
logic internal_rc_osc_en;
logic device_reset;
logic wake_up;
logic timeout_flag;
logic irq;
int bad_count = 0;
int n_tests = 0;
int cyc = 0;
int ev_seen = 0;
int inc_seen = 0;
logic [32:0] exp_rd[$];
logic [34:0] exp_ev[$];

always #25 pclk = ~pclk;

watchdog_timer #(.RC_DIVIDE(RDIV), .BASE_TICK_COUNT(BTC)) u_dut (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.clear_watchdog_instr(clear_watchdog_instr),
	.sleep_instr(sleep_instr),
	.in_sleep(in_sleep),
	.general_timer_event(general_timer_event),
	.general_timer_inc(general_timer_inc),
	.internal_rc_osc_en(internal_rc_osc_en),
	.device_reset(device_reset),
	.wake_up(wake_up),
	.timeout_flag(timeout_flag),
	.irq(irq)
);

////////////////////////////////////////////////////////////////////////////
task automatic chk(string name, logic [63:0] seen, logic [63:0] exp);
	n_tests++;
	if (seen !== exp) begin
		bad_count++;
		$display("wrong value %s expected %0h seen %0h", name, exp, seen);
	end
endtask

task print_verdict;
	$display("comparisons %0d mismatches %0d", n_tests, bad_count);
	if (bad_count == 0 && n_tests > 0)
		$display("ALL CHECKS OK");
	else
		$display("CHECKS NOT OK");
	$finish;
endtask

// The request is held until pready is seen high at a rising edge.
task automatic apb(logic wr, logic [15:0] a, logic [31:0] d, logic [32:0] e);
	@(posedge pclk);
	if (!wr)
		exp_rd.push_back(e);
	psel <= 1;
	penable <= 0;
	pwrite <= wr;
	paddr <= a;
	pwdata <= d;
	@(posedge pclk);
	penable <= 1;
	do @(posedge pclk); while (pready !== 1'b1);
	psel <= 0;
	penable <= 0;
endtask

task automatic wr(logic [15:0] a, logic [31:0] d);
	apb(1, a, d, '0);
endtask

task automatic rd(logic [15:0] a, logic [31:0] e);
	apb(0, a, 0, {1'b0, e});
endtask

task automatic kick(logic slp, output int a);
	@(posedge pclk);
	if (slp)
		sleep_instr <= 1;
	else
		clear_watchdog_instr <= 1;
	@(posedge pclk);
	a = cyc;
	sleep_instr <= 0;
	clear_watchdog_instr <= 0;
endtask

task automatic cirq(logic e);
	#1;
	chk("irq", irq, e);
endtask

// Early kicks must hold the expiry off; only the last one times the run.
task automatic run(logic [7:0] pc, logic slp, int k, int kicks);
	int a;
	int p;
	p = pc[3] ? P << pc[2:0] : P;
	in_sleep <= slp;
	wr(PRESCALER_CONTROL_ADDR, pc);
	wr(CONFIG_WORD_ADDR, 8'hFF);
	repeat (kicks) begin
		kick(1'($urandom_range(1)), a);
		repeat ($urandom_range(p - 4, 1)) @(posedge pclk);
	end
	kick(0, a);
	for (int i = 1; i <= k; i++)
		exp_ev.push_back({a + p * i + 1, slp, !slp, 1'b0});
	while (exp_ev.size() > 0)
		@(posedge pclk);
	wr(CONFIG_WORD_ADDR, 0);
	rd(WDT_STATUS_ADDR, {pc[3], 2'b00});
	kick(1, a);
	rd(WDT_STATUS_ADDR, {pc[3], 2'b01});
	rd(PRESCALER_CONTROL_ADDR, pc);
endtask

task automatic tmr(int n);
	repeat (n) begin
		@(posedge pclk);
		general_timer_event <= 1;
		@(posedge pclk);
		general_timer_event <= 0;
		repeat ($urandom_range(2)) @(posedge pclk);
	end
	repeat (3) @(posedge pclk);
endtask

////////////////////////////////////////////////////////////////////////////
always @(posedge pclk) begin
	logic [34:0] e;
	cyc <= cyc + 1;
	if (psel && penable)
		chk("pready", pready, 1'b1);
	if (psel && penable && pready && !pwrite)
		chk("read", {pslverr, prdata}, exp_rd.pop_front());
	if (device_reset === 1'b1 || wake_up === 1'b1) begin
		ev_seen++;
		e = exp_ev.size() > 0 ? exp_ev.pop_front() : '1;
		chk("expiry", {cyc, wake_up, device_reset, timeout_flag}, e);
	end
	if (general_timer_inc === 1'b1)
		inc_seen++;
	// A hang counts as a failure and ends the run here.
	if (cyc > LIMIT) begin
		bad_count++;
		print_verdict;
	end
end

initial begin
	int a;
	int b;
	void'($urandom(32'hF967A22C));
	repeat (8) @(posedge pclk);
	presetn <= 1;
	rd(PRESCALER_CONTROL_ADDR, 8'hFF);
	rd(CONFIG_WORD_ADDR, 8'hFF);
	rd(WDT_STATUS_ADDR, 3'h7);
	rd(IRQ_MASK_ADDR, 0);
	rd(IRQ_STATUS_ADDR, 0);
	apb(0, 16'h0010, 0, {1'b1, 32'h0});
	$display("test reset values done");
	run(8'h00, 0, 2, 0);
	run(8'h00, 1, 1, 2);
	for (int n = 0; n < 4; n++)
		run(8'h08 | 8'(n), 1'($urandom_range(1)), 1, 1 + n);
	$display("test expiry done");
	rd(IRQ_STATUS_ADDR, 2'h3);
	cirq(0);
	wr(IRQ_MASK_ADDR, 1);
	cirq(1);
	wr(IRQ_STATUS_ADDR, 1);
	cirq(0);
	wr(IRQ_MASK_ADDR, 3);
	cirq(1);
	wr(IRQ_STATUS_ADDR, 2);
	cirq(0);
	rd(IRQ_STATUS_ADDR, 0);
	$display("test interrupt done");
	in_sleep <= 0;
	wr(CONFIG_WORD_ADDR, 0);
	kick(0, a);
	b = ev_seen;
	repeat (300) @(posedge pclk);
	chk("osc_en", internal_rc_osc_en, 0);
	chk("expiries", ev_seen, b);
	$display("test fuse done");
	wr(PRESCALER_CONTROL_ADDR, 8'h02);
	b = inc_seen;
	tmr(16);
	chk("timer_incs", inc_seen - b, 4);
	wr(PRESCALER_CONTROL_ADDR, 8'h0A);
	b = inc_seen;
	tmr(16);
	chk("timer_incs", inc_seen - b, 0);
	wr(PRESCALER_CONTROL_ADDR, 8'h00);
	b = inc_seen;
	tmr(8);
	chk("timer_incs", inc_seen - b, 8);
	$display("test timer path done");
	print_verdict;
end

endmodule
